// ---- hw/psm_pkg.sv ----
// Package with constants and types of the power-save mode controller
package psm_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WKEN_OFS = 8'h04;
  localparam logic [7:0] WKEDG_OFS = 8'h08;
  localparam logic [7:0] WKPND_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] TMR_OFS = 8'h14;

  // Control register field positions
  localparam int CTRL_HALT_BIT = 0;
  localparam int CTRL_IDLE_BIT = 1;
  localparam int CTRL_DLY_BIT = 2;
  localparam int CTRL_IDLE_TIMER_IRQ_ENABLE_BIT = 3;
  localparam int CTRL_CMEN_BIT = 4;

  // Status register field positions
  localparam int STAT_PND_BIT = 0;
  localparam int STAT_STATE_LSB = 1;

  // Reset values
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [15:0] TMR_RST = 16'h0000;

  // Timing counts
  localparam int TC_DIV = 10;
  localparam logic [15:0] STAB_LOAD = 16'h0100;
  localparam int TOGGLE_BIT = 12;

  // Power-save controller states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_IDLE = 2'b10,
    ST_STAB = 2'b11
  } psm_state_t;

endpackage

// ---- hw/psm_tmr_if.sv ----
// Interface between the sequencer and its idle timer
`timescale 1ns/1ns
interface psm_tmr_if;
  logic run;
  logic load;
  logic countDown;
  logic tick;
  logic toggle;
  logic expired;
  logic [15:0] count;

  modport ctrl (output run, output load, output countDown,
                input tick, input toggle, input expired, input count);
  modport timer (input run, input load, input countDown,
                 output tick, output toggle, output expired, output count);
endinterface

// ---- hw/psm_idle_timer.sv ----
// Instruction-cycle divider and free-running idle timer
`timescale 1ns/1ns
module psm_idle_timer (
  input wire logic clk,
  input wire logic rst_n,
  psm_tmr_if.timer tif
);

  logic [3:0] divCnt_r;
  logic [3:0] divCnt_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;

  // Divide the oscillator by ten to form the instruction cycle [R07]
  always_comb begin
    divCnt_nxt = divCnt_r;
    if (tif.run) begin
      if (divCnt_r == 4'(psm_pkg::TC_DIV - 1)) begin
        divCnt_nxt = 4'h0;
      end else begin
        divCnt_nxt = divCnt_r + 4'h1;
      end
    end
  end

  assign tif.tick = tif.run && (divCnt_r == 4'(psm_pkg::TC_DIV - 1));

  // Load 256 on wake, count down during stabilisation, else count up
  always_comb begin
    count_nxt = count_r;
    if (tif.load) begin
      count_nxt = psm_pkg::STAB_LOAD; // [R06]
    end else if (tif.tick) begin
      if (tif.countDown) begin
        count_nxt = (count_r == 16'h0000) ? count_r : count_r - 16'h0001;
      end else begin
        count_nxt = count_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 4'h0;
      count_r <= psm_pkg::TMR_RST;
    end else begin
      divCnt_r <= divCnt_nxt;
      count_r <= count_nxt;
    end
  end

  // Bit twelve flips when the low twelve bits wrap
  assign tif.toggle = tif.tick && !tif.countDown &&
                      (count_r[psm_pkg::TOGGLE_BIT-1:0] == 12'hFFF); // [R13]
  assign tif.expired = tif.countDown && (count_r == 16'h0000);
  assign tif.count = count_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // No tick within the nine clocks that follow a tick
  property p_tick_spacing;
    tif.tick |=> (!tif.tick)[*8] ##1 !tif.tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) // [R07]
    else $error("instruction tick spacing wrong");

  // Ten running clocks after a tick bring the next one
  sequence s_ten_running;
    tif.tick ##1 tif.run[*8] ##1 tif.run ##1 tif.run;
  endsequence
  property p_tick_period;
    s_ten_running |-> tif.tick;
  endproperty
  a_tick_period: assert property (p_tick_period) // [R07]
    else $error("instruction tick missing after ten clocks");

  property p_load_value;
    tif.load |=> tif.count == psm_pkg::STAB_LOAD;
  endproperty
  a_load_value: assert property (p_load_value) // [R06]
    else $error("idle timer not loaded with 256");

endmodule // psm_idle_timer

// ---- hw/psm_wake.sv ----
// Multi-input wake-up port: synchroniser, edge select and pending flags
`timescale 1ns/1ns
module psm_wake #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] wakePins,
  input wire logic [WIDTH-1:0] edgeSel,
  input wire logic clrStrobe,
  input wire logic [WIDTH-1:0] keepMask,
  output logic [WIDTH-1:0] pending
);

  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] pend_r;
  logic [WIDTH-1:0] pend_nxt;
  logic [WIDTH-1:0] hit;

  // Edge select: one picks a falling edge, zero a rising edge
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      hit[i] = edgeSel[i] ? (prev_r[i] && !sync2_r[i])
                          : (!prev_r[i] && sync2_r[i]);
    end
    pend_nxt = pend_r;
    if (clrStrobe) begin
      pend_nxt = pend_r & keepMask;
    end
    pend_nxt = pend_nxt | hit; // Set wins over a same-cycle clear
  end

  // Two-stage synchroniser, then edge history and pending flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r <= '0;
      pend_r <= '0;
    end else begin
      sync1_r <= wakePins;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      pend_r <= pend_nxt;
    end
  end

  assign pending = pend_r;

endmodule // psm_wake

// ---- hw/psm_ctrl.sv ----
// Power-save mode sequencer with APB register file
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
// Function
// R01: Writing one to halt flag stops clock, timers and all activity.
// R02: Halt inhibits supervisor; enabled clock monitor drives fault output low.
// R03: Enabled selected edge on wake-up port ends halt.
// R04: Rising edge on oscillator output pin ends halt, RC oscillator only.
// R05: Reset input low leaves halt through normal reset.
// R06: Wake enables oscillator, loads timer 256, clocks chip after expiry.
// R07: Instruction clock is oscillator divided by ten.
// R08: RC option inserts delay only if startup delay select set; reset clears.
// R09: Halt-disable option makes halt writes ineffective.
// R10: Idle stops all but oscillator, supervisor, clock monitor, idle timer.
// R11: Power-save keeps RAM, registers, I/O and other timers unchanged.
// R12: Idle ends on reset or enabled wake-up edge.
// R13: Idle ends when idle timer bit twelve toggles.
// R14: Each bit-twelve toggle sets sticky pending flag until software clears.
// R15: Idle timer interrupt requested only with its enable set.
// R16: With interrupt enabled, service routine runs then returns after idle.
// R17: With interrupt disabled, execution resumes after idle entry.
// R18: Software places two no-ops after halt or idle entry.
// R19: Halt refused while any wake-up bit enabled and pending.
// R20: Halt and idle flags clear automatically when exit completes.
module psm_ctrl #(
  parameter bit HALT_DISABLE = 1'b0,
  parameter bit RC_OSC = 1'b1,
  parameter int WAKE_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [WAKE_WIDTH-1:0] wakePins,
  input wire logic oscOutputPin,
  output logic coreClkEn,
  output logic oscEnable,
  output logic supervisorEnable,
  output logic supervisorFaultOut_n,
  output logic idleTimerIrq,
  output logic wakeResume
);

  // Register offset decode, shared by the read and write paths
  function automatic logic [2:0] regSel(input logic [7:0] a);
    case (a)
      psm_pkg::CTRL_OFS: regSel = 3'h1;
      psm_pkg::WKEN_OFS: regSel = 3'h2;
      psm_pkg::WKEDG_OFS: regSel = 3'h3;
      psm_pkg::WKPND_OFS: regSel = 3'h4;
      psm_pkg::STAT_OFS: regSel = 3'h5;
      psm_pkg::TMR_OFS: regSel = 3'h6;
      default: regSel = 3'h0;
    endcase
  endfunction

  psm_tmr_if tif ();

  psm_pkg::psm_state_t state_r;
  psm_pkg::psm_state_t state_nxt;
  logic haltFlag_r, haltFlag_nxt;
  logic idleFlag_r, idleFlag_nxt;
  logic dlySel_r, dlySel_nxt;
  logic idle_timer_irq_enable_r, idle_timer_irq_enable_nxt;
  logic cmEn_r, cmEn_nxt;
  logic idle_timer_pending_r, idle_timer_pending_nxt;
  logic [WAKE_WIDTH-1:0] wkEn_r, wkEn_nxt;
  logic [WAKE_WIDTH-1:0] wkEdg_r, wkEdg_nxt;
  logic [WAKE_WIDTH-1:0] wkPnd;
  logic [31:0] prdata_r, prdata_nxt;
  logic slvErr_r, slvErr_nxt;
  logic fault_r, fault_nxt;
  logic irq_r, irq_nxt;
  logic resume_r, resume_nxt;
  logic oscSync1_r, oscSync2_r, oscPrev_r;
  logic wrEn, wakeHit, haltBlocked, oscRise, pndClr;
  logic [2:0] wrSel;

  // Wake-up port edges and pending flags [R03]
  psm_wake #(
    .WIDTH(WAKE_WIDTH)
  ) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .wakePins(wakePins),
    .edgeSel(wkEdg_r),
    .clrStrobe(wrEn && (wrSel == 3'h4)),
    .keepMask(pwdata[WAKE_WIDTH-1:0]),
    .pending(wkPnd)
  );

  psm_idle_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tif(tif)
  );

  // Oscillator pin passes two flops before edge detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscSync1_r <= 1'b0;
      oscSync2_r <= 1'b0;
      oscPrev_r <= 1'b0;
    end else begin
      oscSync1_r <= oscOutputPin;
      oscSync2_r <= oscSync1_r;
      oscPrev_r <= oscSync2_r;
    end
  end

  assign oscRise = RC_OSC && oscSync2_r && !oscPrev_r; // [R04]
  assign wakeHit = |(wkEn_r & wkPnd);
  assign haltBlocked = wakeHit; // [R19]
  assign wrEn = psel && penable && pwrite;
  assign wrSel = regSel(paddr);
  assign pndClr = wrEn && (wrSel == 3'h5) && pwdata[psm_pkg::STAT_PND_BIT];

  // Halt stops the divider and timer, so its count is held [R01] [R11]
  assign tif.run = (state_r != psm_pkg::ST_HALT);
  assign tif.countDown = (state_r == psm_pkg::ST_STAB);

  // Sequencer next state and flag auto-clear
  always_comb begin
    state_nxt = state_r;
    tif.load = 1'b0;
    resume_nxt = 1'b0;
    case (state_r)
      psm_pkg::ST_RUN: begin
        if (haltFlag_r && !haltBlocked && !HALT_DISABLE) begin
          state_nxt = psm_pkg::ST_HALT; // [R01] [R19]
        end else if (idleFlag_r) begin
          state_nxt = psm_pkg::ST_IDLE; // [R10]
        end
      end
      psm_pkg::ST_HALT: begin
        if (wakeHit || oscRise) begin
          // Crystal always waits; RC waits only when selected [R08]
          if (!RC_OSC || dlySel_r) begin
            state_nxt = psm_pkg::ST_STAB; // [R06]
            tif.load = 1'b1;
          end else begin
            state_nxt = psm_pkg::ST_RUN; // [R03] [R04]
            resume_nxt = 1'b1;
          end
        end
      end
      psm_pkg::ST_IDLE: begin
        if (wakeHit || tif.toggle) begin
          state_nxt = psm_pkg::ST_RUN; // [R12] [R13]
          resume_nxt = 1'b1;
        end
      end
      psm_pkg::ST_STAB: begin
        if (tif.expired) begin
          state_nxt = psm_pkg::ST_RUN; // [R06]
          resume_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = psm_pkg::ST_RUN;
      end
    endcase
  end

  // Control register writes; exits clear the request flags
  always_comb begin
    haltFlag_nxt = haltFlag_r;
    idleFlag_nxt = idleFlag_r;
    dlySel_nxt = dlySel_r;
    idle_timer_irq_enable_nxt = idle_timer_irq_enable_r;
    cmEn_nxt = cmEn_r;
    wkEn_nxt = wkEn_r;
    wkEdg_nxt = wkEdg_r;
    if (wrEn && (wrSel == 3'h1)) begin
      // A halt request is dropped at once if it cannot be honoured
      haltFlag_nxt = pwdata[psm_pkg::CTRL_HALT_BIT] && !HALT_DISABLE &&
                     !haltBlocked; // [R09] [R19]
      idleFlag_nxt = pwdata[psm_pkg::CTRL_IDLE_BIT];
      dlySel_nxt = pwdata[psm_pkg::CTRL_DLY_BIT];
      idle_timer_irq_enable_nxt = pwdata[psm_pkg::CTRL_IDLE_TIMER_IRQ_ENABLE_BIT];
      cmEn_nxt = pwdata[psm_pkg::CTRL_CMEN_BIT];
    end
    if (wrEn && (wrSel == 3'h2)) begin
      wkEn_nxt = pwdata[WAKE_WIDTH-1:0];
    end
    if (wrEn && (wrSel == 3'h3)) begin
      wkEdg_nxt = pwdata[WAKE_WIDTH-1:0];
    end
    if (resume_nxt) begin
      haltFlag_nxt = 1'b0; // [R20]
      idleFlag_nxt = 1'b0; // [R20]
    end
  end

  // Sticky pending flag and gated interrupt request
  always_comb begin
    idle_timer_pending_nxt = idle_timer_pending_r;
    if (pndClr) begin
      idle_timer_pending_nxt = 1'b0;
    end
    if (tif.toggle) begin
      idle_timer_pending_nxt = 1'b1; // [R14]
    end
    // Core vectors to the handler or resumes inline on this level
    irq_nxt = idle_timer_pending_nxt && idle_timer_irq_enable_nxt; // [R15] [R16] [R17]
    fault_nxt = !(cmEn_nxt && (state_nxt == psm_pkg::ST_HALT)); // [R02]
  end

  // Read data is sampled in the setup phase so pready can stay high
  always_comb begin
    prdata_nxt = prdata_r;
    slvErr_nxt = slvErr_r;
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      slvErr_nxt = (regSel(paddr) == 3'h0);
      case (regSel(paddr))
        3'h1: begin
          prdata_nxt[psm_pkg::CTRL_HALT_BIT] = haltFlag_r;
          prdata_nxt[psm_pkg::CTRL_IDLE_BIT] = idleFlag_r;
          prdata_nxt[psm_pkg::CTRL_DLY_BIT] = dlySel_r;
          prdata_nxt[psm_pkg::CTRL_IDLE_TIMER_IRQ_ENABLE_BIT] = idle_timer_irq_enable_r;
          prdata_nxt[psm_pkg::CTRL_CMEN_BIT] = cmEn_r;
        end
        3'h2: prdata_nxt[WAKE_WIDTH-1:0] = wkEn_r;
        3'h3: prdata_nxt[WAKE_WIDTH-1:0] = wkEdg_r;
        3'h4: prdata_nxt[WAKE_WIDTH-1:0] = wkPnd;
        3'h5: begin
          prdata_nxt[psm_pkg::STAT_PND_BIT] = idle_timer_pending_r;
          prdata_nxt[psm_pkg::STAT_STATE_LSB +: 2] = state_r;
        end
        3'h6: prdata_nxt[15:0] = tif.count;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Reset returns to run and clears the delay select [R05] [R08]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= psm_pkg::ST_RUN;
      haltFlag_r <= 1'b0;
      idleFlag_r <= 1'b0;
      dlySel_r <= 1'b0;
      idle_timer_irq_enable_r <= 1'b0;
      cmEn_r <= 1'b0;
      idle_timer_pending_r <= 1'b0;
      wkEn_r <= psm_pkg::WAKE_RST;
      wkEdg_r <= psm_pkg::WAKE_RST;
      prdata_r <= 32'h0000_0000;
      slvErr_r <= 1'b0;
      fault_r <= 1'b1;
      irq_r <= 1'b0;
      resume_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      haltFlag_r <= haltFlag_nxt;
      idleFlag_r <= idleFlag_nxt;
      dlySel_r <= dlySel_nxt;
      idle_timer_irq_enable_r <= idle_timer_irq_enable_nxt;
      cmEn_r <= cmEn_nxt;
      idle_timer_pending_r <= idle_timer_pending_nxt;
      wkEn_r <= wkEn_nxt;
      wkEdg_r <= wkEdg_nxt;
      prdata_r <= prdata_nxt;
      slvErr_r <= slvErr_nxt;
      fault_r <= fault_nxt;
      irq_r <= irq_nxt;
      resume_r <= resume_nxt;
    end
  end

  // Chip clocks only in run; supervisor off only in halt [R02] [R10]
  assign coreClkEn = (state_r == psm_pkg::ST_RUN); // [R01] [R06]
  assign oscEnable = (state_r != psm_pkg::ST_HALT);
  assign supervisorEnable = (state_r != psm_pkg::ST_HALT);
  assign supervisorFaultOut_n = fault_r;
  assign idleTimerIrq = irq_r;
  assign wakeResume = resume_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && slvErr_r;
  assign prdata = prdata_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_halt_entry;
    state_r == psm_pkg::ST_RUN && haltFlag_r && !wakeHit && !HALT_DISABLE
      |=> state_r == psm_pkg::ST_HALT && !coreClkEn;
  endproperty
  a_halt_entry: assert property (p_halt_entry) // [R01]
    else $error("halt not entered");

  property p_halt_frozen;
    state_r == psm_pkg::ST_HALT ##1 state_r == psm_pkg::ST_HALT
      |-> $stable(tif.count) && !supervisorEnable;
  endproperty
  a_halt_frozen: assert property (p_halt_frozen) // [R11]
    else $error("timer or supervisor active in halt");

  property p_fault;
    state_r == psm_pkg::ST_HALT && cmEn_r |-> !supervisorFaultOut_n;
  endproperty
  a_fault: assert property (p_fault) // [R02]
    else $error("clock monitor fault not driven in halt");

  property p_wake_exit;
    state_r == psm_pkg::ST_HALT && wakeHit |=> state_r != psm_pkg::ST_HALT;
  endproperty
  a_wake_exit: assert property (p_wake_exit) // [R03]
    else $error("wake edge did not end halt");

  property p_no_halt;
    HALT_DISABLE |-> state_r != psm_pkg::ST_HALT && !haltFlag_r;
  endproperty
  a_no_halt: assert property (p_no_halt) // [R09]
    else $error("halt entered with halt disabled");

  sequence s_stab_start;
    state_r == psm_pkg::ST_HALT ##1 state_r == psm_pkg::ST_STAB;
  endsequence
  property p_stab_load;
    s_stab_start |-> tif.count == psm_pkg::STAB_LOAD && !coreClkEn;
  endproperty
  a_stab_load: assert property (p_stab_load) // [R06]
    else $error("stabilisation did not start at 256");

  property p_idle_toggle;
    state_r == psm_pkg::ST_IDLE && tif.toggle
      |=> state_r == psm_pkg::ST_RUN && idle_timer_pending_r ##1 !idleFlag_r[*1];
  endproperty
  a_idle_toggle: assert property (p_idle_toggle) // [R13]
    else $error("idle not left on timer toggle");

  property p_pnd_set;
    tif.toggle |=> idle_timer_pending_r ##1 (irq_r == idle_timer_irq_enable_r);
  endproperty
  a_pnd_set: assert property (p_pnd_set) // [R14]
    else $error("pending flag not set on toggle");

  property p_irq_gate;
    irq_r |-> idle_timer_irq_enable_r && idle_timer_pending_r;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R15]
    else $error("interrupt raised without enable");

  property p_refuse;
    state_r == psm_pkg::ST_RUN && wakeHit |=> state_r != psm_pkg::ST_HALT;
  endproperty
  a_refuse: assert property (p_refuse) // [R19]
    else $error("halt entered with wake-up pending");

  property p_autoclr;
    wakeResume |-> !haltFlag_r && !idleFlag_r &&
                   state_r == psm_pkg::ST_RUN;
  endproperty
  a_autoclr: assert property (p_autoclr) // [R20]
    else $error("request flag not cleared on exit");

endmodule // psm_ctrl

// ---- testbench/psm_far_end.sv ----
// Far-side model: wake-up port pins and oscillator output pin
`timescale 1ns/1ns
module psm_far_end #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  output logic [WIDTH-1:0] wakePins,
  output logic oscOutputPin
);
  // Pins rest low; levels only move on a command from the bench
  initial begin
    wakePins = '0;
    oscOutputPin = 1'b0;
  end

  // Change one wake pin just after a rising edge, then hold the level
  task automatic set_pin(input int k, input logic v);
    @(posedge clk);
    wakePins[k] <= v;
  endtask

  // Low-to-high on the oscillator pin; held high long enough to be seen
  task automatic osc_rise();
    @(posedge clk);
    oscOutputPin <= 1'b1;
    repeat (6) @(posedge clk);
    oscOutputPin <= 1'b0;
  endtask
endmodule // psm_far_end

// ---- testbench/power_save_mode_control_test.sv ----
// Self-checking bench of the power-save controller over APB
`timescale 1ns/1ns
module power_save_mode_control_test;
  typedef struct {logic [31:0] d; logic e; logic rd;} psm_note_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] wakePins;
  logic oscOutputPin, coreClkEn, oscEnable, supervisorEnable;
  logic supervisorFaultOut_n, idleTimerIrq, wakeResume;
  int miscompares = 0;
  int tests_run = 0;
  int k, n;
  psm_note_t notes[$];

  psm_ctrl i_psm_ctrl (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wakePins(wakePins), .oscOutputPin(oscOutputPin),
    .coreClkEn(coreClkEn), .oscEnable(oscEnable),
    .supervisorEnable(supervisorEnable),
    .supervisorFaultOut_n(supervisorFaultOut_n),
    .idleTimerIrq(idleTimerIrq), .wakeResume(wakeResume));
  psm_far_end i_psm_far_end (.clk(clk), .wakePins(wakePins),
    .oscOutputPin(oscOutputPin));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; the expected answer is noted before the access
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    notes.push_back('{exp, err, !w});
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    // A missing answer counts against the run
    if (pready !== 1'b1)
      cmp("pready", 32'h0000_0001, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Watcher: each completed access takes the oldest note
  always @(posedge clk) begin
    psm_note_t nt;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      nt = notes.pop_front();
      if (nt.rd)
        cmp("prdata", nt.d, prdata);
      cmp("pslverr", {31'h0000_0000, nt.e}, {31'h0000_0000, pslverr});
    end
  end

  // Count cycles until the resume pulse, sampled away from the edge
  task automatic wait_resume(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (wakeResume !== 1'b1 && cnt < lim);
  endtask

  task automatic flags(input logic [3:0] exp);
    @(negedge clk);
    cmp("coreClkEn osc sup fault_n", {28'h000_0000, exp},
        {28'h000_0000, coreClkEn, oscEnable, supervisorEnable,
         supervisorFaultOut_n});
  endtask

  // Hang guard of 70000 clocks, well above the longest idle wait of 41100
  initial begin
    #(8 * 70000);
    miscompares++;
    close_out();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    void'($urandom(32'hef3b));
    k = $urandom % 8;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    apb(0, psm_pkg::CTRL_OFS, 0, 32'h0000_0000, 0);
    apb(0, psm_pkg::WKEN_OFS, 0, 32'h0000_0000, 0);
    apb(0, psm_pkg::STAT_OFS, 0, 32'h0000_0000, 0);
    apb(0, 8'h3C, 0, 32'h0000_0000, 1);
    // Halt with clock monitor on, left by the oscillator pin
    apb(1, psm_pkg::CTRL_OFS, 32'h0000_0011, 0, 0);
    repeat (2) @(posedge clk); // Two idle slots as software must leave
    flags(4'b0000);
    // Watch for the resume pulse while the pin is still held high
    fork
      i_psm_far_end.osc_rise();
      wait_resume(20, n);
    join
    cmp("osc wake", 32'h0000_0001, {31'h0, n < 20});
    flags(4'b1111);
    apb(0, psm_pkg::CTRL_OFS, 0, 32'h0000_0010, 0);
    // Pending enabled wake bit refuses halt
    apb(1, psm_pkg::WKEN_OFS, 32'h1 << k, 0, 0);
    apb(1, psm_pkg::WKEDG_OFS, 32'h0000_0000, 0, 0);
    apb(1, psm_pkg::WKPND_OFS, 32'h0000_0000, 0, 0);
    i_psm_far_end.set_pin(k, 1'b1);
    repeat (5) @(posedge clk);
    apb(0, psm_pkg::WKPND_OFS, 0, 32'h1 << k, 0);
    apb(1, psm_pkg::CTRL_OFS, 32'h0000_0001, 0, 0);
    flags(4'b1111);
    apb(0, psm_pkg::CTRL_OFS, 0, 32'h0000_0000, 0);
    i_psm_far_end.set_pin(k, 1'b0);
    apb(1, psm_pkg::WKPND_OFS, 32'h0000_0000, 0, 0);
    apb(0, psm_pkg::WKPND_OFS, 0, 32'h0000_0000, 0);
    // Halt with start-up delay, left by the wake port
    apb(1, psm_pkg::CTRL_OFS, 32'h0000_0005, 0, 0);
    repeat (2) @(posedge clk);
    flags(4'b0001);
    apb(0, psm_pkg::STAT_OFS, 0, 32'h0000_0002, 0);
    i_psm_far_end.set_pin(k, 1'b1);
    wait_resume(2700, n);
    // 256 instruction cycles of ten clocks; the divider phase is not
    // reset on load, so the first cycle may be short
    cmp("stab span", 32'h0000_0001,
        {31'h0, n >= 2555 && n <= 2570});
    apb(0, psm_pkg::CTRL_OFS, 0, 32'h0000_0004, 0);
    apb(0, psm_pkg::WKEN_OFS, 0, 32'h1 << k, 0);
    i_psm_far_end.set_pin(k, 1'b0);
    apb(1, psm_pkg::WKPND_OFS, 32'h0000_0000, 0, 0);
    // Reset pulled low in halt
    apb(1, psm_pkg::CTRL_OFS, 32'h0000_0001, 0, 0);
    repeat (2) @(posedge clk);
    flags(4'b0001);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    flags(4'b1111);
    apb(0, psm_pkg::CTRL_OFS, 0, 32'h0000_0000, 0);
    // Idle with timer interrupt enabled, ended by the bit-12 toggle
    apb(1, psm_pkg::CTRL_OFS, 32'h0000_000A, 0, 0);
    repeat (2) @(posedge clk);
    flags(4'b0111);
    wait_resume(41100, n);
    cmp("idle exit", 32'h0000_0001, {31'h0, n < 41100});
    @(negedge clk);
    cmp("irq", 32'h0000_0001, {31'h0, idleTimerIrq});
    apb(0, psm_pkg::STAT_OFS, 0, 32'h0000_0001, 0);
    apb(0, psm_pkg::CTRL_OFS, 0, 32'h0000_0008, 0);
    apb(1, psm_pkg::CTRL_OFS, 32'h0000_0000, 0, 0);
    @(negedge clk);
    cmp("irq masked", 32'h0000_0000, {31'h0, idleTimerIrq});
    apb(0, psm_pkg::STAT_OFS, 0, 32'h0000_0001, 0);
    apb(1, psm_pkg::STAT_OFS, 32'h0000_0001, 0, 0);
    apb(0, psm_pkg::STAT_OFS, 0, 32'h0000_0000, 0);
    close_out();
  end
endmodule // power_save_mode_control_test
